// ==== src/elbs_top.sv ====
// file: endian byte lane steering top
// Functional notes
// - endian mode comes from select pin
// - big: first stream byte lane three
// - little: first stream byte lane zero
// - big rom: location zero to lane three
// - little rom: location zero to lane zero
// - internal lanes never change with mode
// - slave accesses work in both modes
// - full words never repositioned
// - sub-word decode moves address, not lane
// - received bytes go to ascending addresses
// - sent bytes leave from address zero upward
// - address zero on lane 0 or 3
// - control register zero at 03h or 00h
// - internal processor addressing always little
`timescale 1ns/1ps
module elbs_top
  import elbs_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        big_lit_sel,
  input  wire elbs_req_t   host_req,
  input  wire logic [31:0] reg_rdata,
  output elbs_rsp_t        host_rsp,
  output logic [7:0]       reg_addr_int,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_word_valid,
  output logic [31:0]      rx_word,
  output logic [3:0]       rx_word_be,
  input  wire logic        rx_flush,
  input  wire logic        tx_load,
  input  wire logic [31:0] tx_word,
  input  wire logic        tx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  output logic             tx_busy,
  input  wire logic [7:0]  script_addr,
  output logic [7:0]       script_reg_addr
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [1:0]  rx_cnt;
    logic [31:0] rx_acc;
    logic [3:0]  rx_be;
    logic        rx_out_v;
    logic [31:0] rx_out;
    logic [3:0]  rx_out_be;
    logic [1:0]  tx_cnt;
    logic [31:0] tx_buf;
    logic        tx_act;
    logic [7:0]  tx_out;
    elbs_rsp_t   rsp;
    logic [7:0]  iaddr;
  } elbs_state_t;

  elbs_state_t s_q, s_d;
  logic        be_mode;
  logic [1:0]  rx_lane, tx_lane, req_lane;

  assign be_mode = big_lit_sel;

  elbs_lane_map u_rx_map (.big_endian(be_mode), .offset(s_q.rx_cnt), .lane(rx_lane));
  elbs_lane_map u_tx_map (.big_endian(be_mode), .offset(s_q.tx_cnt), .lane(tx_lane));
  elbs_lane_map u_rq_map (.big_endian(be_mode), .offset(host_req.addr[1:0]), .lane(req_lane));

  // ****************************************************************
  // host access decode
  // ****************************************************************
  logic [3:0] req_be;
  logic [7:0] req_iaddr;
  logic [1:0] half_lane;
  always_comb begin
    half_lane = be_mode ? (req_lane - 2'h1) : req_lane;
    case (host_req.size)
      ELBS_SZ_WORD: req_be = ELBS_BE_ALL;
      ELBS_SZ_HALF: req_be = 4'h3 << {half_lane[1], 1'b0};
      ELBS_SZ_BYTE: req_be = 4'h1 << req_lane;
      default:      req_be = ELBS_BE_NONE;
    endcase
    // internal register index = word base + lowest physical lane
    case (host_req.size)
      ELBS_SZ_WORD: req_iaddr = {host_req.addr[7:2], 2'h0};
      ELBS_SZ_HALF: req_iaddr = {host_req.addr[7:2], half_lane[1], 1'b0};
      default:      req_iaddr = {host_req.addr[7:2], req_lane};
    endcase
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d           = s_q;
    s_d.rx_out_v  = 1'b0;
    s_d.rsp.valid = 1'b0;
    // rx: byte k of stream goes to address k, lane from mode
    if (rx_valid) begin
      s_d.rx_acc[rx_lane*8 +: 8] = rx_byte;
      s_d.rx_be[rx_lane]         = 1'b1;
      s_d.rx_cnt                 = s_q.rx_cnt + 2'h1;
      if (s_q.rx_cnt == ELBS_LANE_TOP) begin
        s_d.rx_out_v  = 1'b1;
        s_d.rx_out    = s_d.rx_acc;
        s_d.rx_out_be = s_d.rx_be;
        s_d.rx_be     = ELBS_BE_NONE;
        s_d.rx_acc    = ELBS_WORD_RESET;
      end
    end else if (rx_flush && (s_q.rx_be != ELBS_BE_NONE)) begin
      s_d.rx_out_v  = 1'b1;
      s_d.rx_out    = s_q.rx_acc;
      s_d.rx_out_be = s_q.rx_be;
      s_d.rx_acc    = ELBS_WORD_RESET;
      s_d.rx_be     = ELBS_BE_NONE;
      s_d.rx_cnt    = ELBS_CNT_RESET;
    end
    // tx: address zero first, lane from mode
    if (!s_q.tx_act) begin
      if (tx_load) begin
        s_d.tx_act = 1'b1;
        s_d.tx_buf = tx_word;
        s_d.tx_cnt = ELBS_CNT_RESET;
        s_d.tx_out = be_mode ? tx_word[31:24] : tx_word[7:0];
      end
    end else if (tx_ready) begin
      s_d.tx_cnt = s_q.tx_cnt + 2'h1;
      if (s_q.tx_cnt == ELBS_LANE_TOP) begin
        s_d.tx_act = 1'b0;
      end else begin
        s_d.tx_out = s_q.tx_buf[((be_mode ? (ELBS_LANE_TOP - s_d.tx_cnt) : s_d.tx_cnt))*8 +: 8];
      end
    end
    // host slave / rom access, physical lanes untouched
    if (host_req.valid) begin
      s_d.rsp.valid    = 1'b1;
      s_d.rsp.lane_en  = req_be;
      s_d.rsp.reg_addr = req_iaddr;
      s_d.rsp.data     = host_req.write ? host_req.wdata : reg_rdata;
    end
    // script processor addressing ignores the pin
    s_d.iaddr = script_addr;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign host_rsp        = s_q.rsp;
  assign reg_addr_int    = req_iaddr;
  assign rx_word_valid   = s_q.rx_out_v;
  assign rx_word         = s_q.rx_out;
  assign rx_word_be      = s_q.rx_out_be;
  assign tx_valid        = s_q.tx_act;
  assign tx_byte         = s_q.tx_out;
  assign tx_busy         = s_q.tx_act;
  assign script_reg_addr = s_q.iaddr;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_first_rx_lane: assert property (@(posedge clk) disable iff (!resetn)
    (rx_valid && s_q.rx_cnt == ELBS_CNT_RESET) |=> (s_q.rx_be == (be_mode ? 4'h8 : 4'h1)))
    else $error("first rx byte on wrong lane");
  a_rx_le_lane: assert property (@(posedge clk) disable iff (!resetn)
    (rx_valid && !be_mode && s_q.rx_cnt == ELBS_CNT_RESET) |=> s_q.rx_acc[7:0] == $past(rx_byte))
    else $error("little rx byte zero misplaced");
  a_word_no_move: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_WORD) |=> host_rsp.lane_en == ELBS_BE_ALL)
    else $error("word access repositioned");
  a_byte_lane: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_BYTE) |=>
      host_rsp.lane_en == (4'h1 << (be_mode ? (2'h3 - $past(host_req.addr[1:0])) : $past(host_req.addr[1:0]))))
    else $error("byte lane mapping wrong");
  a_reg_zero: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_BYTE &&
     host_req.addr == (be_mode ? ELBS_SCTL0_BE : ELBS_SCTL0_LE)) |=> host_rsp.reg_addr == ELBS_SCTL0_LE)
    else $error("control register zero decode wrong");
  a_rsp_valid: assert property (@(posedge clk) disable iff (!resetn)
    host_req.valid |=> host_rsp.valid)
    else $error("slave access not answered");
  a_tx_first: assert property (@(posedge clk) disable iff (!resetn)
    (!s_q.tx_act && tx_load) |=> tx_byte == (be_mode ? $past(tx_word[31:24]) : $past(tx_word[7:0])))
    else $error("tx address zero not first");
  a_script_addr: assert property (@(posedge clk) disable iff (!resetn)
    1'b1 |=> script_reg_addr == $past(script_addr))
    else $error("script address altered");
  a_half_lanes: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_HALF) |=>
      host_rsp.lane_en == (($past(be_mode) ^ $past(host_req.addr[1])) ? 4'hc : 4'h3))
    else $error("half word lanes wrong");
  a_rd_data_fixed: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && !host_req.write) |=> host_rsp.data == $past(reg_rdata))
    else $error("read data lanes moved");
  a_wr_data_fixed: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.write) |=> host_rsp.data == $past(host_req.wdata))
    else $error("write data lanes moved");
  a_word_addr: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_WORD) |=> host_rsp.reg_addr == {$past(host_req.addr[7:2]), 2'h0})
    else $error("word register address wrong");
  a_addr_int: assert property (@(posedge clk) disable iff (!resetn)
    (host_req.valid && host_req.size == ELBS_SZ_BYTE) |->
      reg_addr_int == {host_req.addr[7:2], be_mode ? (ELBS_LANE_TOP - host_req.addr[1:0]) : host_req.addr[1:0]})
    else $error("internal byte address wrong");
  a_rx_word_out: assert property (@(posedge clk) disable iff (!resetn)
    (rx_valid && s_q.rx_cnt == ELBS_LANE_TOP) |=> (rx_word_valid && rx_word_be == ELBS_BE_ALL))
    else $error("full rx word not emitted");
  a_flush_out: assert property (@(posedge clk) disable iff (!resetn)
    (!rx_valid && rx_flush && s_q.rx_be != ELBS_BE_NONE) |=> (rx_word_valid && rx_word_be == $past(s_q.rx_be)))
    else $error("partial rx word not emitted");
  a_tx_hold: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.tx_act && !tx_ready) |=> (tx_valid && $stable(tx_byte)))
    else $error("tx byte changed while stalled");
  a_tx_done: assert property (@(posedge clk) disable iff (!resetn)
    (s_q.tx_act && tx_ready && s_q.tx_cnt == ELBS_LANE_TOP) |=> !tx_valid)
    else $error("tx did not end after four bytes");

endmodule : elbs_top

// ==== src/elbs_pkg.sv ====
// package: shared types and constants for endian byte lane steering
package elbs_pkg;

  localparam int          ELBS_LANES      = 4;
  localparam logic [1:0]  ELBS_LANE_TOP   = 2'h3;
  localparam logic [7:0]  ELBS_SCTL0_LE   = 8'h00;
  localparam logic [7:0]  ELBS_SCTL0_BE   = 8'h03;
  localparam logic [1:0]  ELBS_CNT_RESET  = 2'h0;
  localparam logic [3:0]  ELBS_BE_NONE    = 4'h0;
  localparam logic [3:0]  ELBS_BE_ALL     = 4'hf;
  localparam logic [31:0] ELBS_WORD_RESET = 32'h0000_0000;
  localparam logic [7:0]  ELBS_BYTE_RESET = 8'h00;

  typedef enum logic [1:0] {
    ELBS_SZ_BYTE = 2'h0,
    ELBS_SZ_HALF = 2'h1,
    ELBS_SZ_WORD = 2'h2
  } elbs_size_t;

  // host side request (slave access, rom read)
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    elbs_size_t size;
    logic [31:0] wdata;
  } elbs_req_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  lane_en;
    logic [7:0]  reg_addr;
    logic [31:0] data;
  } elbs_rsp_t;

endpackage : elbs_pkg

// ==== src/elbs_lane_map.sv ====
// file: lane mapping leaf for one byte offset
`timescale 1ns/1ps
module elbs_lane_map
  import elbs_pkg::*;
(
  input  wire logic       big_endian,
  input  wire logic [1:0] offset,
  output logic      [1:0] lane
);

  // big: lane 3 minus offset, little: lane equals offset
  assign lane = big_endian ? (ELBS_LANE_TOP - offset) : offset;

endmodule : elbs_lane_map

// ==== bench/elbs_host_model.sv ====
// far side model: register read data and a byte consumer that can stall
`timescale 1ns/1ps
module elbs_host_model (
  input  wire logic   clk,
  input  wire logic   resetn,
  input  wire logic   slow,
  output logic [31:0] reg_rdata,
  output logic        tx_ready
);
  logic ph_q;
  // fixed physical lanes, never swapped
  assign reg_rdata = 32'h4433_2211;
  // slow consumer is ready every other cycle
  assign tx_ready  = !slow || ph_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) ph_q <= 1'b0;
    else ph_q <= !ph_q;
  end
endmodule : elbs_host_model

// ==== bench/tb.sv ====
// self-checking bench for endian byte lane steering
`timescale 1ns/1ps
module tb
  import elbs_pkg::*;
;
  logic        clk = 0, resetn = 0, big = 0, slow = 0;
  elbs_req_t   req = '0;
  elbs_rsp_t   rsp;
  logic [31:0] rdata, rxw, txw = '0;
  logic        rxv = 0, flush = 0, txl = 0, txr, txv, busy, rwv;
  logic [7:0]  rxb = '0, txb, sa = '0, sra, rai;
  logic [3:0]  rbe;
  int          n_fail = 0, checked = 0, cyc = 0;
  always #50 clk = ~clk;
  elbs_top uut (.clk(clk), .resetn(resetn), .big_lit_sel(big), .host_req(req), .reg_rdata(rdata),
    .host_rsp(rsp), .reg_addr_int(rai), .rx_valid(rxv), .rx_byte(rxb), .rx_word_valid(rwv),
    .rx_word(rxw), .rx_word_be(rbe), .rx_flush(flush), .tx_load(txl), .tx_word(txw),
    .tx_ready(txr), .tx_valid(txv), .tx_byte(txb), .tx_busy(busy), .script_addr(sa),
    .script_reg_addr(sra));
  elbs_host_model pm (.clk(clk), .resetn(resetn), .slow(slow), .reg_rdata(rdata), .tx_ready(txr));
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_fail == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic t_host();
    logic [1:0] ln;
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 5; i++) begin
        @(negedge clk);
        big = m[0];
        req = '{1'b1, i[0], i[7:0], (i == 4) ? ELBS_SZ_WORD : ELBS_SZ_BYTE, 32'ha1b2_c3d4};
        ln = m[0] ? 2'h3 - i[1:0] : i[1:0];
        @(negedge clk);
        req.valid = 1'b0;
        chk("reg_addr_int", rai, (i == 4) ? 8'h04 : {6'h0, ln});
        chk("rsp_valid", rsp.valid, 32'h1);
        chk("lane_en", rsp.lane_en, (i == 4) ? 4'hf : 4'h1 << ln);
        chk("reg_addr", rsp.reg_addr, (i == 4) ? 8'h04 : {6'h0, ln});
        chk("rsp_data", rsp.data, i[0] ? 32'ha1b2_c3d4 : rdata);
      end
    end
  endtask : t_host
  task automatic t_rx(logic m, int n);
    logic [31:0] w = '0;
    logic [3:0]  be = '0;
    for (int k = 0; k < n; k++) begin
      @(negedge clk);
      big = m;
      rxv = 1'b1;
      rxb = 8'h10 + k[7:0];
      w[8*(m ? 3-k : k) +: 8] = rxb;
      be[m ? 3-k : k] = 1'b1;
    end
    @(negedge clk);
    rxv = 1'b0;
    flush = (n < 4);
    if (n < 4) @(negedge clk);
    flush = 1'b0;
    chk("rx_valid", rwv, 32'h1);
    chk("rx_word", rxw, w);
    chk("rx_be", rbe, be);
  endtask : t_rx
  task automatic t_tx(logic m);
    logic [7:0] got[$];
    @(negedge clk);
    big = m;
    // little runs a fast consumer, big a stalling one
    slow = m;
    txl = 1'b1;
    txw = 32'h0403_0201;
    @(negedge clk);
    // second load while busy must be dropped
    txw = 32'hffff_ffff;
    chk("tx_busy", busy, 32'h1);
    for (int c = 0; c < 20; c++) begin
      if (txv && txr) got.push_back(txb);
      @(negedge clk);
      txl = 1'b0;
    end
    chk("tx_count", got.size(), 32'h4);
    chk("tx_idle", busy, 32'h0);
    foreach (got[k]) chk("tx_byte", got[k], m ? 4 - k : k + 1);
  endtask : t_tx
  task automatic t_half();
    logic [1:0] lo;
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      big = m[0];
      req = '{1'b1, 1'b0, 8'h08 + {6'h0, m[1], 1'b0}, ELBS_SZ_HALF, 32'h0};
      lo  = (m[0] ^ m[1]) ? 2'h2 : 2'h0;
      @(negedge clk);
      req.valid = 1'b0;
      chk("half_lane_en", rsp.lane_en, lo[1] ? 4'hc : 4'h3);
      chk("half_reg_addr", rsp.reg_addr, 8'h08 + {6'h0, lo});
    end
    // host patches a script word as one dword, bytes unswapped
    @(negedge clk);
    req = '{1'b1, 1'b1, 8'h10, ELBS_SZ_WORD, 32'h1122_3344};
    @(negedge clk);
    req.valid = 1'b0;
    chk("patch_data", rsp.data, 32'h1122_3344);
    chk("patch_lane_en", rsp.lane_en, 32'hf);
  endtask : t_half
  task automatic t_reset();
    @(negedge clk);
    txl = 1'b1;
    txw = 32'h0403_0201;
    sa  = 8'h5a;
    @(negedge clk);
    txl = 1'b0;
    resetn = 1'b0;
    @(negedge clk);
    chk("rst_busy", busy, 32'h0);
    chk("rst_tx_byte", txb, 32'h0);
    chk("rst_script", sra, 32'h0);
    resetn = 1'b1;
    @(negedge clk);
    chk("post_rst_script", sra, sa);
  endtask : t_reset
  task automatic t_script();
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      big = m[0];
      sa = 8'h3c + m[7:0];
      @(negedge clk);
      chk("script_addr", sra, sa);
    end
  endtask : t_script
  initial begin
    repeat (6) @(negedge clk);
    resetn = 1'b1;
    t_host();
    t_half();
    t_rx(1'b0, 4);
    t_rx(1'b1, 4);
    t_rx(1'b1, 2);
    t_tx(1'b0);
    t_tx(1'b1);
    t_reset();
    t_script();
    report_and_stop();
  end
endmodule : tb
